// [verilog/fptu_regs.svh]
// fptu_regs.svh: constants for the parameter-table and identifier readout link
// assumes: included by both ends, the checks and the bench, definitions only
`ifndef FPTU_REGS_SVH
`define FPTU_REGS_SVH
// opcodes
`define FPTU_OP_UID        8'h5A
`define FPTU_OP_PTAB       8'h5B
`define FPTU_OP_RDSR       8'h05
`define FPTU_OP_WRSR       8'h01
`define FPTU_OP_READ       8'h03
`define FPTU_OP_DPD        8'hB9
`define FPTU_OP_REL        8'hAB
// identifier window
`define FPTU_UID_BASE      8'h80
`define FPTU_UID_LAST      8'h8B
// table fields
`define FPTU_QW_DUMMY      5'b0_0100
`define FPTU_QW_MODE       3'b010
`define FPTU_QW_OPC        8'hEB
`define FPTU_RSVD_BYTE     8'hFF
`define FPTU_ST1_SIZE      8'h0C
`define FPTU_ST1_OPC       8'h20
`define FPTU_ST2_SIZE      8'h0F
`define FPTU_ST2_OPC       8'h52
`define FPTU_ST3_SIZE      8'h10
`define FPTU_ST3_OPC       8'hD8
`define FPTU_ST4_SIZE      8'h00
`define FPTU_ST4_OPC       8'hFF
`define FPTU_ARRAY_ERASED  8'hFF
`define FPTU_STATUS_RESET  8'h00
// table addresses
`define FPTU_A_48          8'h48
`define FPTU_A_49          8'h49
`define FPTU_A_4A          8'h4A
`define FPTU_A_4B          8'h4B
`define FPTU_A_4C          8'h4C
`define FPTU_A_4D          8'h4D
`define FPTU_A_4E          8'h4E
`define FPTU_A_4F          8'h4F
`define FPTU_A_50          8'h50
`define FPTU_A_51          8'h51
`define FPTU_A_52          8'h52
`define FPTU_A_53          8'h53
// timing, ns, at 50 ns clock
`define FPTU_CLK_NS        50
`define FPTU_T_PU_NS       100000
`define FPTU_T_DP_NS       3000
`define FPTU_T_RES1_NS     3000
`define FPTU_T_RES2_NS     1800
`define FPTU_T_W_NS        30000000
// least time rounds up, longest rounds down
`define FPTU_PU_CYC        ((`FPTU_T_PU_NS + `FPTU_CLK_NS - 1) / `FPTU_CLK_NS)
`define FPTU_DP_CYC        (`FPTU_T_DP_NS / `FPTU_CLK_NS)
`define FPTU_RES1_CYC      (`FPTU_T_RES1_NS / `FPTU_CLK_NS)
`define FPTU_RES2_CYC      (`FPTU_T_RES2_NS / `FPTU_CLK_NS)
`define FPTU_W_CYC         (`FPTU_T_W_NS / `FPTU_CLK_NS)
// host divider: half period in system clocks
`define FPTU_HALF_DIV      4'h4
`endif

// [verilog/fptu_pkg.sv]
// fptu_pkg.sv: request kind type used by the host end and the bench
// assumes: fptu_regs.svh on the include path
package fptu_pkg;
   // host request kinds
   typedef enum logic [2:0]
   {
      FPTU_REQ_UID  = 3'b000,
      FPTU_REQ_PTAB = 3'b001,
      FPTU_REQ_RDSR = 3'b010,
      FPTU_REQ_WRSR = 3'b011,
      FPTU_REQ_DPD  = 3'b100,
      FPTU_REQ_REL  = 3'b101,
      FPTU_REQ_READ = 3'b110
   } fptu_req_t;
endpackage

// [verilog/fptu_link_if.sv]
// fptu_link_if.sv: serial link between host and flash end
// assumes: no pin resolution, host samples the data-out value whatever its enable
`timescale 1ns/1ns
interface fptu_link_if;
   logic sclk;        // serial clock, host made
   logic cs_n;        // chip select, active low
   logic mosi;        // host to device data
   logic miso_o;      // device output value
   logic miso_oe_n;   // device output enable, low drives
   modport dev  (input sclk, cs_n, mosi, output miso_o, miso_oe_n);
   modport host (output sclk, cs_n, mosi, input miso_o, miso_oe_n);
endinterface

// [verilog/fptu_dev.sv]
// fptu_dev.sv: flash end answering table, identifier, status and power commands
// assumes: link clock far slower than sys_clk_i, mode 0 framing
`timescale 1ns/1ns
`include "fptu_regs.svh"
module fptu_dev
#(
   parameter logic [95:0] UID_VALUE = 96'h0123_4567_89AB_CDEF_0011_2233, // arbitrary per-die value
   parameter int          W_CYC     = `FPTU_W_CYC                          // status write busy length
)
(
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic reset_i,
   // link
   fptu_link_if.dev  link,
   // user side status
   output logic      powered_down_o,
   output logic      busy_o
);
   import fptu_pkg::*;
   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers, first stage read only by the second
   logic [2:0] s1_reg;
   logic [2:0] s2_reg;
   logic       sclk_d_reg;
   always_ff @(posedge sys_clk_i)
   begin
      s1_reg     <= {link.sclk, link.cs_n, link.mosi};
      s2_reg     <= s1_reg;
      sclk_d_reg <= s2_reg[2];
   end
   wire sclk_s = s2_reg[2];
   wire cs_s   = s2_reg[1];
   wire mosi_s = s2_reg[0];
   wire rise   = sclk_s & ~sclk_d_reg & ~cs_s;
   wire fall   = ~sclk_s & sclk_d_reg & ~cs_s;
   logic cs_d_reg;
   always_ff @(posedge sys_clk_i)
      cs_d_reg <= reset_i ? 1'b1 : cs_s;
   wire cs_rise = cs_s & ~cs_d_reg;
   ////////////////////////////////////////////////////////////////////////
   // table byte lookup
   function automatic logic [7:0] ptab_byte(input logic [7:0] a);
      logic [7:0] b;
      b = `FPTU_RSVD_BYTE;
      if (a == `FPTU_A_4A) b = {`FPTU_QW_MODE, `FPTU_QW_DUMMY};
      else if (a == `FPTU_A_4B) b = `FPTU_QW_OPC;
      else if (a == `FPTU_A_4C) b = `FPTU_ST1_SIZE;
      else if (a == `FPTU_A_4D) b = `FPTU_ST1_OPC;
      else if (a == `FPTU_A_4E) b = `FPTU_ST2_SIZE;
      else if (a == `FPTU_A_4F) b = `FPTU_ST2_OPC;
      else if (a == `FPTU_A_50) b = `FPTU_ST3_SIZE;
      else if (a == `FPTU_A_51) b = `FPTU_ST3_OPC;
      else if (a == `FPTU_A_52) b = `FPTU_ST4_SIZE;
      else if (a == `FPTU_A_53) b = `FPTU_ST4_OPC;
      return b;
   endfunction
   // identifier byte, ascending address over 80h..8Bh; any address outside reads the 80h byte
   function automatic logic [7:0] uid_byte(input logic [7:0] a);
      logic [3:0] i;
      i = (a >= `FPTU_UID_BASE && a <= `FPTU_UID_LAST) ? 4'(a - `FPTU_UID_BASE) : 4'h0;
      return UID_VALUE[8'(95 - 8 * i) -: 8];
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // frame state
   typedef enum logic [2:0]
   {
      FPTU_D_OPC   = 3'b000,
      FPTU_D_ADDR  = 3'b001,
      FPTU_D_DUMMY = 3'b010,
      FPTU_D_OUT   = 3'b011,
      FPTU_D_WDATA = 3'b100,
      FPTU_D_IDLE  = 3'b101
   } fptu_dstate_t;
   fptu_dstate_t st_reg;
   logic [7:0]  sh_reg;         // input shifter
   logic [2:0]  bit_reg;        // bit in byte
   logic [1:0]  ab_reg;         // address byte count
   logic [7:0]  op_reg;         // latched opcode
   logic [7:0]  addr_reg;       // byte address, low byte
   logic [7:0]  out_reg;        // output shifter
   logic        oe_n_reg;       // output enable, low drives
   logic [7:0]  status_reg;     // status contents
   logic        dp_reg;         // deep power-down
   logic [31:0] tmr_reg;        // latency timer
   logic [1:0]  pend_reg;       // 1 enter dp, 2 leave dp, 3 status write
   wire [7:0] sh_next = {sh_reg[6:0], mosi_s};
   wire       byte_done = rise & (bit_reg == 3'h7);
   // byte served for the current read address
   wire [7:0] rd_byte = (op_reg == `FPTU_OP_UID)  ? uid_byte(addr_reg) :
                        (op_reg == `FPTU_OP_PTAB) ? ptab_byte(addr_reg) :
                        (op_reg == `FPTU_OP_RDSR) ? status_reg :
                        `FPTU_ARRAY_ERASED;
   wire has_addr = (sh_next == `FPTU_OP_UID) | (sh_next == `FPTU_OP_PTAB) | (sh_next == `FPTU_OP_READ);
   ////////////////////////////////////////////////////////////////////////
   // frame decoding and output shifting
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i | cs_s)
      begin
         st_reg   <= FPTU_D_OPC;
         bit_reg  <= 3'h0;
         ab_reg   <= 2'h0;
         oe_n_reg <= 1'b1;
         sh_reg   <= 8'h00;
         if (reset_i)
         begin
            op_reg   <= 8'h00;
            addr_reg <= 8'h00;
            out_reg  <= 8'h00;
         end
      end
      else
      begin
         if (rise)
         begin
            sh_reg  <= sh_next;
            bit_reg <= bit_reg + 3'h1;
         end
         // output changes on the falling edge
         if (fall && st_reg == FPTU_D_OUT)
         begin
            oe_n_reg <= 1'b0;
            if (bit_reg == 3'h0)
            begin
               out_reg  <= rd_byte;
               addr_reg <= addr_reg + 8'h01;
            end
            else
               out_reg <= {out_reg[6:0], 1'b0};
         end
         if (byte_done)
         begin
            case (st_reg)
               FPTU_D_OPC:
               begin
                  op_reg <= sh_next;
                  // asleep: only release is heard
                  if (dp_reg && sh_next != `FPTU_OP_REL) st_reg <= FPTU_D_IDLE;
                  else if (has_addr) st_reg <= FPTU_D_ADDR;
                  else if (sh_next == `FPTU_OP_RDSR) st_reg <= FPTU_D_OUT;
                  else if (sh_next == `FPTU_OP_WRSR) st_reg <= FPTU_D_WDATA;
                  else st_reg <= FPTU_D_IDLE;
               end
               FPTU_D_ADDR:
               begin
                  ab_reg   <= ab_reg + 2'h1;
                  addr_reg <= sh_next;
                  if (ab_reg == 2'h2)
                     st_reg <= (op_reg == `FPTU_OP_READ) ? FPTU_D_OUT : FPTU_D_DUMMY;
               end
               FPTU_D_DUMMY: st_reg <= FPTU_D_OUT;
               FPTU_D_WDATA:
               begin
                  op_reg <= `FPTU_OP_WRSR;
                  addr_reg <= sh_next;                                // written status byte
                  st_reg <= FPTU_D_IDLE;
               end
               default: st_reg <= st_reg;
            endcase
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // power and status write latencies, started at chip select rise
   wire [7:0] frame_op = op_reg;
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         status_reg <= `FPTU_STATUS_RESET;
         dp_reg     <= 1'b0;
         tmr_reg    <= 32'h0000_0000;
         pend_reg   <= 2'h0;
      end
      else if (pend_reg != 2'h0)
      begin
         if (tmr_reg == 32'h0000_0000)
         begin
            pend_reg <= 2'h0;
            if (pend_reg == 2'h1) dp_reg <= 1'b1;
            else if (pend_reg == 2'h2) dp_reg <= 1'b0;
            else status_reg <= addr_reg;
         end
         else
            tmr_reg <= tmr_reg - 32'h0000_0001;
      end
      else if (cs_rise)
      begin
         if (frame_op == `FPTU_OP_DPD && !dp_reg)
         begin
            pend_reg <= 2'h1;
            tmr_reg  <= 32'(`FPTU_DP_CYC - 1);
         end
         else if (frame_op == `FPTU_OP_REL && dp_reg)
         begin
            pend_reg <= 2'h2;
            tmr_reg  <= 32'(`FPTU_RES2_CYC - 1);
         end
         else if (frame_op == `FPTU_OP_WRSR && st_reg == FPTU_D_IDLE && !dp_reg)
         begin
            pend_reg <= 2'h3;
            tmr_reg  <= 32'(W_CYC - 1);
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign link.miso_o    = out_reg[7];
   assign link.miso_oe_n = oe_n_reg;
   assign powered_down_o = dp_reg;
   assign busy_o         = (pend_reg != 2'h0);
endmodule // fptu_dev

// [verilog/fptu_host.sv]
// fptu_host.sv: host end, issues one command frame per request
// assumes: device end on the far side of fptu_link_if, mode 0
`timescale 1ns/1ns
`include "fptu_regs.svh"
module fptu_host
#(
   parameter int PU_CYC = `FPTU_PU_CYC   // power-up wait
)
(
   // clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              reset_i,
   // link
   fptu_link_if.host              link,
   // request
   input  wire logic              req_valid_i,
   input  wire fptu_pkg::fptu_req_t req_kind_i,
   input  wire logic [7:0]        req_addr_i,
   input  wire logic [7:0]        req_wdata_i,
   input  wire logic [3:0]        req_len_i,
   output logic                   req_ready_o,
   // answer
   output logic                   rd_valid_o,
   output logic [7:0]             rd_data_o,
   output logic                   done_o
);
   import fptu_pkg::*;
   ////////////////////////////////////////////////////////////////////////
   // power-up hold-off before any command
   logic [31:0] pu_reg;
   wire pu_ok = (pu_reg == 32'h0000_0000);
   always_ff @(posedge sys_clk_i)
      if (reset_i) pu_reg <= 32'(PU_CYC);
      else if (!pu_ok) pu_reg <= pu_reg - 32'h0000_0001;
   ////////////////////////////////////////////////////////////////////////
   // frame builder: up to 5 out bytes, then read bytes
   function automatic logic [7:0] opc_of(input fptu_req_t k);
      logic [7:0] o;
      o = `FPTU_OP_RDSR;
      case (k)
         FPTU_REQ_UID:  o = `FPTU_OP_UID;
         FPTU_REQ_PTAB: o = `FPTU_OP_PTAB;
         FPTU_REQ_WRSR: o = `FPTU_OP_WRSR;
         FPTU_REQ_DPD:  o = `FPTU_OP_DPD;
         FPTU_REQ_REL:  o = `FPTU_OP_REL;
         FPTU_REQ_READ: o = `FPTU_OP_READ;
         default:       o = `FPTU_OP_RDSR;
      endcase
      return o;
   endfunction
   logic [47:0] tx_reg;       // bytes to send, msb first
   logic [5:0]  txb_reg;      // bits left to send
   logic [6:0]  rxb_reg;      // bits left to receive
   logic [7:0]  rx_reg;       // receive shifter
   logic [2:0]  rcnt_reg;     // bits in current byte
   logic [3:0]  div_reg;      // clock divider
   logic        sclk_reg;
   logic        cs_n_reg;
   logic        busy_reg;
   logic [1:0]  gap_reg;      // deselect gap
   logic        rdv_reg;
   logic        done_reg;
   logic [7:0]  rdd_reg;
   // uid command: opcode, 3 address bytes forming 80h, dummy byte
   wire uid = (req_kind_i == FPTU_REQ_UID);
   wire [7:0] a0 = uid ? `FPTU_UID_BASE : req_addr_i;
   wire [7:0] opc = opc_of(req_kind_i);
   wire has_addr = (req_kind_i == FPTU_REQ_UID) | (req_kind_i == FPTU_REQ_PTAB) | (req_kind_i == FPTU_REQ_READ);
   wire [5:0] tx_bits = has_addr ? ((req_kind_i == FPTU_REQ_READ) ? 6'd32 : 6'd40) :
                        (req_kind_i == FPTU_REQ_WRSR) ? 6'd16 : 6'd8;
   wire rd_kind = has_addr | (req_kind_i == FPTU_REQ_RDSR);
   wire [6:0] rx_bits = rd_kind ? {req_len_i, 3'b000} : 7'd0;
   assign req_ready_o = ~busy_reg & pu_ok & (gap_reg == 2'h0);
   wire take = req_valid_i & req_ready_o;
   wire tick = (div_reg == `FPTU_HALF_DIV - 4'h1);
   ////////////////////////////////////////////////////////////////////////
   // divider makes sclk; 8 sys clocks per period, below every limit
   always_ff @(posedge sys_clk_i)
   begin
      rdv_reg  <= 1'b0;
      done_reg <= 1'b0;
      if (reset_i)
      begin
         busy_reg <= 1'b0;
         cs_n_reg <= 1'b1;
         sclk_reg <= 1'b0;
         div_reg  <= 4'h0;
         txb_reg  <= 6'd0;
         rxb_reg  <= 7'd0;
         rcnt_reg <= 3'h0;
         tx_reg   <= 48'h0;
         rx_reg   <= 8'h00;
         rdd_reg  <= 8'h00;
         gap_reg  <= 2'h0;
      end
      else if (take)
      begin
         busy_reg <= 1'b1;
         cs_n_reg <= 1'b0;
         div_reg  <= 4'h0;
         tx_reg   <= {opc, 16'h0000, a0, (req_kind_i == FPTU_REQ_WRSR) ? req_wdata_i : 8'h00, 8'h00};
         if (req_kind_i == FPTU_REQ_WRSR)
            tx_reg <= {opc, req_wdata_i, 32'h0000_0000};
         txb_reg  <= tx_bits;
         rxb_reg  <= (rx_bits == 7'd0 && rd_kind) ? 7'd8 : rx_bits;
         rcnt_reg <= 3'h0;
      end
      else if (busy_reg)
      begin
         div_reg <= tick ? 4'h0 : div_reg + 4'h1;
         if (tick)
         begin
            if (txb_reg == 6'd0 && rxb_reg == 7'd0 && !sclk_reg)
            begin
               busy_reg <= 1'b0;
               cs_n_reg <= 1'b1;
               gap_reg  <= 2'h3;
               done_reg <= 1'b1;
            end
            else if (!sclk_reg)
               sclk_reg <= 1'b1;
            else
            begin
               // falling edge: advance out bit while any remain, else sample in bit
               sclk_reg <= 1'b0;
               if (txb_reg != 6'd0)
               begin
                  tx_reg  <= {tx_reg[46:0], 1'b0};
                  txb_reg <= txb_reg - 6'd1;
               end
               else
               begin
                  rx_reg   <= {rx_reg[6:0], link.miso_o};
                  rxb_reg  <= rxb_reg - 7'd1;
                  rcnt_reg <= rcnt_reg + 3'h1;
                  if (rcnt_reg == 3'h7)
                  begin
                     rdd_reg <= {rx_reg[6:0], link.miso_o};
                     rdv_reg <= 1'b1;
                  end
               end
            end
         end
      end
      else if (gap_reg != 2'h0)
         gap_reg <= gap_reg - 2'h1;
   end
   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign link.sclk = sclk_reg;
   assign link.cs_n = cs_n_reg;
   assign link.mosi = tx_reg[47];
   assign rd_valid_o = rdv_reg;
   assign rd_data_o  = rdd_reg;
   assign done_o     = done_reg;
endmodule // fptu_host

// [sim/fptu_props.sv]
// fptu_props.sv: wire checks on the host-device link
// assumes: instantiated beside the link interface, one clock domain
`timescale 1ns/1ns
`include "fptu_regs.svh"
module fptu_props
(
   // clock and reset
   input  wire logic sys_clk_i,
   input  wire logic reset_i,
   // link wires
   input  wire logic sclk,
   input  wire logic cs_n,
   input  wire logic mosi,
   input  wire logic miso_o,
   input  wire logic miso_oe_n
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0] bits_reg;   // sclk rises in this frame
   logic [7:0] opc_reg;    // first byte of the frame
   logic       sclk_reg;   // sclk one cycle back
   wire        rise_w = sclk && !sclk_reg;   // rising link clock
   // count bits, saturating so a long frame cannot wrap to a false small count
   always_ff @(posedge sys_clk_i)
   begin
      sclk_reg <= sclk;
      if (reset_i || cs_n)
      begin
         bits_reg <= 8'h00;
         opc_reg  <= 8'h00;
      end
      else if (rise_w)
      begin
         bits_reg <= (bits_reg == 8'hFF) ? bits_reg : bits_reg + 8'h01;
         opc_reg  <= (bits_reg < 8'h08) ? {opc_reg[6:0], mosi} : opc_reg;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   a_sclk_idle_low: assert property (cs_n |-> !sclk) else $error("link clock moved while deselected");
   a_opcode_quiet: assert property ($fell(cs_n) |-> miso_oe_n [*8]) else $error("output during opcode");
   a_uid_after_dummy: assert property (!miso_oe_n && opc_reg == `FPTU_OP_UID |-> bits_reg >= 8'h28)
      else $error("identifier driven before dummy byte ended");
   a_table_after_dummy: assert property (!miso_oe_n && opc_reg == `FPTU_OP_PTAB |-> bits_reg >= 8'h28)
      else $error("table driven before dummy byte ended");
   a_out_on_fall: assert property (!miso_oe_n && $changed(miso_o) |-> !sclk)
      else $error("output changed while link clock high");
   a_half_period: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk) else $error("bad link clock high time");
   a_mosi_stable: assert property ($rose(sclk) |-> $stable(mosi) [*4]) else $error("host data moved in high phase");
   a_release_after_cs: assert property (cs_n [*4] |-> miso_oe_n) else $error("output still driven after deselect");
   a_whole_bytes: assert property ($rose(cs_n) |-> bits_reg[2:0] == 3'h0) else $error("frame not whole bytes");
   a_cs_high_gap: assert property ($rose(cs_n) |-> cs_n [*3]) else $error("deselect gap too short");
   // main scenarios seen
   c_uid_frame: cover property (opc_reg == `FPTU_OP_UID && $rose(cs_n));
   c_table_out: cover property (opc_reg == `FPTU_OP_PTAB && !miso_oe_n);
   c_sleep_frame: cover property (opc_reg == `FPTU_OP_DPD && $rose(cs_n));
endmodule // fptu_props

// [sim/tb_flash_param_table_and_uid_readout.sv]
// tb_flash_param_table_and_uid_readout.sv: host and flash ends joined, self-checking
// assumes: design files and fptu_props compiled first
`timescale 1ns/1ns
`include "fptu_regs.svh"
module tb_flash_param_table_and_uid_readout;
   import fptu_pkg::*;
   localparam logic [95:0] UID = 96'h5A5A_1234_9876_C3C3_0F0F_7E81; // arbitrary per-die value
   localparam int PU = 10;   // shortened power-up wait
   localparam int WC = 20;   // shortened status write time
   logic       sys_clk_i, reset_i, req_valid, ready, rd_valid, done, pd, busy, drove;
   fptu_req_t  kind;         // request kind
   logic [7:0] addr, wdata, rd_data;
   logic [3:0] len;          // bytes asked
   logic [31:0] rng;         // xorshift state
   logic [7:0] got[$];       // bytes of last frame
   int         miscompares, compares;
   ////////////////////////////////////////////////////////////////////////
   fptu_link_if fptu_link_if_i();
   fptu_host #(.PU_CYC(PU)) fptu_host_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .link(fptu_link_if_i),
      .req_valid_i(req_valid), .req_kind_i(kind), .req_addr_i(addr), .req_wdata_i(wdata), .req_len_i(len),
      .req_ready_o(ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .done_o(done));
   fptu_dev #(.UID_VALUE(UID), .W_CYC(WC)) fptu_dev_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .link(fptu_link_if_i), .powered_down_o(pd), .busy_o(busy));
   fptu_props fptu_props_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .sclk(fptu_link_if_i.sclk),
      .cs_n(fptu_link_if_i.cs_n), .mosi(fptu_link_if_i.mosi), .miso_o(fptu_link_if_i.miso_o),
      .miso_oe_n(fptu_link_if_i.miso_oe_n));
   ////////////////////////////////////////////////////////////////////////
   // table contents; anything outside the window reads erased
   function automatic logic [7:0] tab(input logic [7:0] a);
      case (a)
         8'h4A: return {3'b010, 5'b0_0100};   // mode bits over dummy clocks
         8'h4B: return 8'hEB;
         8'h4C: return 8'h0C;
         8'h4D: return 8'h20;
         8'h4E: return 8'h0F;
         8'h4F: return 8'h52;
         8'h50: return 8'h10;
         8'h51: return 8'hD8;
         8'h52: return 8'h00;
         default: return 8'hFF;
      endcase
   endfunction
   // identifier byte i counted up from the base, msb first
   function automatic logic [7:0] uid_byte(input int i);
      return UID[95 - 8 * (i % 12) -: 8];
   endfunction
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic chk(input logic [95:0] e, input logic [95:0] g);
      compares++;
      if (g !== e)
      begin
         miscompares++;
         $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   // one request, bytes collected until the frame ends
   task automatic run_req(input fptu_req_t k, input logic [7:0] a, input logic [7:0] w, input logic [3:0] n);
      int t;
      t = 0;
      got.delete();
      drove = 1'b0;
      @(negedge sys_clk_i);
      while (ready !== 1'b1 && t < 5000)
      begin
         @(negedge sys_clk_i);
         t++;
      end
      kind = k;
      addr = a;
      wdata = w;
      len = n;
      req_valid = 1'b1;
      @(negedge sys_clk_i);
      req_valid = 1'b0;
      t = 0;
      // a pulse lasts one cycle: look just after each edge
      while (t < 5000)
      begin
         @(posedge sys_clk_i);
         #1;
         t++;
         if (fptu_link_if_i.miso_oe_n === 1'b0) drove = 1'b1;
         if (rd_valid === 1'b1) got.push_back(rd_data);
         if (done === 1'b1) break;
      end
      if (t >= 5000) chk(1, 0);
   endtask
   // cycles until a level reaches the wanted value
   task automatic wait_lvl(ref logic s, input logic v, output int t);
      t = 0;
      while (s !== v && t < 2000)
      begin
         @(negedge sys_clk_i);
         t++;
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   // a hang counts as a mismatch
   initial
   begin
      repeat (40000) @(posedge sys_clk_i);
      miscompares++;
      tally_and_finish();
   end
   initial
   begin : main
      int i;
      int t;
      logic [7:0] a;
      logic [7:0] c[3];
      c = '{8'h48, 8'h47, 8'h4F};
      reset_i = 1'b1;
      req_valid = 1'b0;
      kind = FPTU_REQ_UID;
      addr = 8'h00;
      wdata = 8'h00;
      len = 4'h0;
      rng = 32'h76b3_d3b7;
      miscompares = 0;
      compares = 0;
      repeat (5) @(negedge sys_clk_i);
      reset_i = 1'b0;
      wait_lvl(ready, 1'b1, t);
      chk(1, t >= PU - 1);
      run_req(FPTU_REQ_UID, 8'h00, 8'h00, 4'hD);
      chk(13, got.size());
      for (i = 0; i < got.size(); i++) chk(uid_byte(i), got[i]);
      $display("test identifier done");
      for (i = 0; i < 9; i++)
      begin
         rng = xs(rng);
         a = (i < 3) ? c[i] : 8'h40 + {3'h0, rng[4:0]};
         len = (i < 3) ? 4'hC : {2'h0, rng[9:8]} + 4'h1;
         run_req(FPTU_REQ_PTAB, a, 8'h00, len);
         chk(len, got.size());
         for (t = 0; t < got.size(); t++) chk(tab(a + t[7:0]), got[t]);
      end
      $display("test table done");
      rng = xs(rng);
      run_req(FPTU_REQ_READ, rng[7:0], 8'h00, 4'h4);
      chk(4, got.size());
      for (i = 0; i < 4; i++) chk(8'hFF, got[i]);
      run_req(FPTU_REQ_RDSR, 8'h00, 8'h00, 4'h1);
      chk(`FPTU_STATUS_RESET, got[0]);
      $display("test delivery state done");
      run_req(FPTU_REQ_WRSR, 8'h00, rng[15:8], 4'h0);
      // busy rises only once deselect has crossed the device's synchroniser
      wait_lvl(busy, 1'b1, t);
      chk(1, t <= 5);
      wait_lvl(busy, 1'b0, t);
      chk(1, t <= WC + 8);
      run_req(FPTU_REQ_RDSR, 8'h00, 8'h00, 4'h1);
      chk(rng[15:8], got[0]);
      $display("test status write done");
      run_req(FPTU_REQ_DPD, 8'h00, 8'h00, 4'h0);
      wait_lvl(pd, 1'b1, t);
      chk(1, t <= `FPTU_DP_CYC + 8);
      run_req(FPTU_REQ_RDSR, 8'h00, 8'h00, 4'h1);
      chk(0, drove);
      run_req(FPTU_REQ_REL, 8'h00, 8'h00, 4'h0);
      wait_lvl(pd, 1'b0, t);
      chk(1, t <= `FPTU_RES1_CYC + 8);
      wait_lvl(busy, 1'b0, t);
      run_req(FPTU_REQ_UID, 8'h00, 8'h00, 4'hC);
      for (i = 0; i < 12; i++) chk(uid_byte(i), got[i]);
      $display("test power-down done");
      tally_and_finish();
   end
endmodule // tb_flash_param_table_and_uid_readout
